/* File: rtl/hpcs_top.sv */
// Purpose: Pin-level control and status logic of a multi-loop clock synchronizer
// Assumes: Serial framing sits in a neighbouring block fed from serial_in_o
// Notes:   All pin inputs pass two flops; serial clock is sampled, not used as clock
// Function
// - Data pin bidirectional except four-wire SPI
// - Second pin: address bit one or SPI output
// - Serial clock pin is the bit clock
// - I2C address bit zero from select pin
// - SPI chip select is active low
// - Interrupt low on any status change
// - Reset pin low resets all logic except the pin synchronisers
// - Reset restores register defaults
// - Clock outputs disabled during reset
// - Each enable pin has an output mask
// - Default: pin zero governs all outputs
// - Default: pins one and two ignored
// - Lock pins low when loop unlocked
// - Signal-loss pins follow status bits
// - Decrement pin steps selected loops down
// - Step size comes from a register
// - Select pin high I2C, low SPI
// - Increment pin steps selected loops up
`default_nettype none
module hpcs_top
    import hpcs_pkg::*;
(
    input  wire logic                                       clk_i,
    input  wire logic                                       rst_i,
    input  wire logic                                       device_reset_n_i,
    input  wire logic                                       i2c_select_i,
    input  wire logic                                       serial_clk_i,
    input  wire logic                                       serial_data_i,
    output logic                                            serial_data_o,
    output logic                                            serial_data_oe_o,
    input  wire logic                                       addr_select_bit_one_i,
    output logic                                            spi_serial_out_o,
    output logic                                            spi_serial_out_oe_o,
    input  wire logic                                       shared_select_i,
    input  wire logic                                       out_enable_pin_zero_n_i,
    input  wire logic                                       out_enable_pin_one_n_i,
    input  wire logic                                       out_enable_pin_two_n_i,
    input  wire logic                                       freq_step_up_pin_i,
    input  wire logic                                       freq_step_down_pin_i,
    input  wire logic                                       cfg_we_i,
    input  wire hpcs_pkg::hpcs_cfg_t                        cfg_i,
    input  wire logic                                       tx_bit_i,
    input  wire logic                                       tx_drive_i,
    input  wire logic [hpcs_pkg::NUM_LOOPS-1:0]             loop_locked_i,
    input  wire logic [hpcs_pkg::NUM_INPUTS-1:0]            signal_lost_status_i,
    output hpcs_pkg::hpcs_serial_in_t                       serial_in_o,
    output logic                                            i2c_mode_o,
    output logic                                            spi_selected_o,
    output logic [1:0]                                      i2c_addr_bits_o,
    output logic                                            status_change_irq_n_o,
    input  wire logic                                       irq_clear_i,
    output logic [hpcs_pkg::NUM_OUTS-1:0]                   out_clock_enable_o,
    output logic                                            lock_lost_loop_a_n_o,
    output logic                                            lock_lost_loop_c_n_o,
    output logic                                            lock_lost_loop_d_n_o,
    output logic                                            signal_lost_input0_n_o,
    output logic                                            signal_lost_input1_n_o,
    output logic                                            signal_lost_input2_n_o,
    output logic [hpcs_pkg::NUM_LOOPS-1:0][hpcs_pkg::FREQ_W-1:0] loop_freq_word_o,
    output hpcs_pkg::hpcs_cfg_t                             cfg_o
);
    import hpcs_pkg::*;

    localparam int NSYNC = 9;

    typedef struct packed {
        hpcs_cfg_t                             cfg;
        logic [NUM_LOOPS-1:0][FREQ_W-1:0]      freq;
        logic [NUM_LOOPS-1:0]                  lock_prev;
        logic [NUM_INPUTS-1:0]                 los_prev;
        logic                                  irq_pend;
        logic [NUM_OUTS-1:0]                   oe;
        logic                                  d_out;
        logic                                  d_oe;
        logic                                  s_out;
        logic                                  s_oe;
        logic                                  por_done;
    } hpcs_state_t;

    hpcs_state_t st_q;
    hpcs_state_t st_d;

    // Internal reset combines the system reset and the device reset pin
    logic rst_pin_q1;
    logic rst_pin_q2;
    logic core_rst;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rst_pin_q1 <= 1'b0;
            rst_pin_q2 <= 1'b0;
        end
        else
        begin
            rst_pin_q1 <= device_reset_n_i;
            rst_pin_q2 <= rst_pin_q1;
        end
    end

    assign core_rst = ~rst_pin_q2;

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] lvl;
    logic [NSYNC-1:0] rise;
    logic [NSYNC-1:0] fall;

    assign raw = {freq_step_down_pin_i, freq_step_up_pin_i, out_enable_pin_two_n_i,
                  out_enable_pin_one_n_i, out_enable_pin_zero_n_i, addr_select_bit_one_i,
                  serial_data_i, shared_select_i, serial_clk_i};

    for (genvar g = 0; g < NSYNC; g++)
    begin : g_sync
        hpcs_sync_edge u_sync (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .async_i (raw[g]),
            .level_o (lvl[g]),
            .rise_o  (rise[g]),
            .fall_o  (fall[g])
        );
    end

    logic i2c_sel_q1;
    logic i2c_sel_q2;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            i2c_sel_q1 <= 1'b1;
            i2c_sel_q2 <= 1'b1;
        end
        else
        begin
            i2c_sel_q1 <= i2c_select_i;
            i2c_sel_q2 <= i2c_sel_q1;
        end
    end

    logic mode_i2c;
    assign mode_i2c = i2c_sel_q2;

    logic [NUM_OE_PINS-1:0] oe_pin_n;
    assign oe_pin_n = lvl[6:4];

    function automatic logic [NUM_OUTS-1:0] oe_eval(
        input logic [NUM_OE_PINS-1:0][NUM_OUTS-1:0] mask,
        input logic [NUM_OE_PINS-1:0]               pin_n
    );
        logic [NUM_OUTS-1:0] en;
        en = '1;
        for (int p = 0; p < NUM_OE_PINS; p++)
            if (pin_n[p])
                en = en & ~mask[p];
        return en;
    endfunction : oe_eval

    logic [NUM_LOOPS-1:0] los_cur;
    logic                 status_evt;

    always_comb
    begin
        st_d = st_q;
        if (cfg_we_i)
            st_d.cfg = cfg_i;
        // Enable pins gate only the outputs their mask selects
        st_d.oe = oe_eval(st_q.cfg.oe_mask, oe_pin_n);
        for (int l = 0; l < NUM_LOOPS; l++)
        begin
            if (st_q.cfg.step_mask[l] && rise[7] && !rise[8])
                st_d.freq[l] = st_q.freq[l] + FREQ_W'(st_q.cfg.step_size);
            else if (st_q.cfg.step_mask[l] && rise[8] && !rise[7])
                st_d.freq[l] = st_q.freq[l] - FREQ_W'(st_q.cfg.step_size);
        end
        st_d.lock_prev = loop_locked_i;
        st_d.los_prev  = signal_lost_status_i;
        // Set wins over a clear arriving in the same cycle
        if (status_evt)
            st_d.irq_pend = 1'b1;
        else if (irq_clear_i)
            st_d.irq_pend = 1'b0;
        // Data pin drives only in bidirectional modes
        st_d.d_out = tx_bit_i;
        st_d.d_oe  = tx_drive_i & (mode_i2c | ~st_q.cfg.spi_four_wire)
                     & (mode_i2c | ~lvl[1]);
        st_d.s_out = tx_bit_i;
        st_d.s_oe  = tx_drive_i & ~mode_i2c & st_q.cfg.spi_four_wire & ~lvl[1];
        if (mode_i2c)
            st_d.d_out = 1'b0;
        st_d.por_done = 1'b1;
    end

    assign los_cur    = signal_lost_status_i;
    // First cycle after reset has no history to compare against
    assign status_evt = st_q.por_done &&
                        ((loop_locked_i != st_q.lock_prev) || (los_cur != st_q.los_prev));

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q                 <= '0;
            st_q.cfg.oe_mask[0]  <= OE0_MASK_RST;
            st_q.cfg.oe_mask[1]  <= OE12_MASK_RST;
            st_q.cfg.oe_mask[2]  <= OE12_MASK_RST;
            st_q.cfg.step_mask   <= STEP_MSK_RST;
            st_q.cfg.step_size   <= STEP_SIZE_RST;
            st_q.freq            <= {NUM_LOOPS{FREQ_RST}};
        end
        else if (core_rst)
        begin
            st_q                 <= '0;
            st_q.cfg.oe_mask[0]  <= OE0_MASK_RST;
            st_q.cfg.oe_mask[1]  <= OE12_MASK_RST;
            st_q.cfg.oe_mask[2]  <= OE12_MASK_RST;
            st_q.cfg.step_mask   <= STEP_MSK_RST;
            st_q.cfg.step_size   <= STEP_SIZE_RST;
            st_q.freq            <= {NUM_LOOPS{FREQ_RST}};
        end
        else
            st_q <= st_d;
    end

    assign serial_in_o.clk_q    = lvl[0];
    assign serial_in_o.clk_rise = rise[0];
    assign serial_in_o.clk_fall = fall[0];
    assign serial_in_o.sel_q    = lvl[1];
    assign serial_in_o.data_q   = lvl[2];
    assign serial_in_o.sel1_q   = lvl[3];

    assign i2c_mode_o          = mode_i2c;
    assign spi_selected_o      = ~mode_i2c & ~lvl[1];
    assign i2c_addr_bits_o     = mode_i2c ? {lvl[3], lvl[1]} : 2'b00;
    assign serial_data_o       = st_q.d_out;
    assign serial_data_oe_o    = st_q.d_oe;
    assign spi_serial_out_o    = st_q.s_out;
    assign spi_serial_out_oe_o = st_q.s_oe;

    assign status_change_irq_n_o = ~st_q.irq_pend;
    assign out_clock_enable_o    = core_rst ? '0 : st_q.oe;

    assign lock_lost_loop_a_n_o   = st_q.lock_prev[0];
    assign lock_lost_loop_c_n_o   = st_q.lock_prev[1];
    assign lock_lost_loop_d_n_o   = st_q.lock_prev[2];
    assign signal_lost_input0_n_o = ~st_q.los_prev[0];
    assign signal_lost_input1_n_o = ~st_q.los_prev[1];
    assign signal_lost_input2_n_o = ~st_q.los_prev[2];
    assign loop_freq_word_o       = st_q.freq;
    assign cfg_o                  = st_q.cfg;

    chk_oe_reset_off: assert property (@(posedge clk_i)
        disable iff (rst_i)
        core_rst |-> out_clock_enable_o == '0)
        else $error("outputs on in reset");
    chk_oe_zero_all: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!core_rst && st_q.cfg.oe_mask[0] == OE0_MASK_RST && oe_pin_n[0])
        |=> st_q.oe == '0)
        else $error("pin zero failed to gate");
    // Pins one and two may toggle freely while their masks are empty
    chk_oe_unmasked: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!core_rst && st_q.cfg.oe_mask[1] == '0 && st_q.cfg.oe_mask[2] == '0
            && !oe_pin_n[0]) |=> st_q.oe == '1)
        else $error("unmasked output off");
    chk_step_up_once: assert property (@(posedge clk_i)
        disable iff (rst_i || core_rst)
        (rise[7] && !rise[8] && st_q.cfg.step_mask[0] && !cfg_we_i)
        |=> st_q.freq[0] == $past(st_q.freq[0]) + FREQ_W'($past(st_q.cfg.step_size)))
        else $error("step up wrong");
    chk_step_down_once: assert property (@(posedge clk_i)
        disable iff (rst_i || core_rst)
        (rise[8] && !rise[7] && st_q.cfg.step_mask[0])
        |=> st_q.freq[0] == $past(st_q.freq[0]) - FREQ_W'($past(st_q.cfg.step_size)))
        else $error("step down wrong");
    chk_step_hold: assert property (@(posedge clk_i)
        disable iff (rst_i || core_rst)
        (!rise[7] && !rise[8]) |=> $stable(st_q.freq))
        else $error("step without edge");
    chk_irq_on_change: assert property (@(posedge clk_i)
        disable iff (rst_i || core_rst)
        status_evt |=> !status_change_irq_n_o)
        else $error("irq missed");
    // A clear with no new event must release the pin
    chk_irq_clear: assert property (@(posedge clk_i)
        disable iff (rst_i || core_rst)
        (irq_clear_i && !status_evt) |=> status_change_irq_n_o)
        else $error("irq not cleared");
    chk_four_wire_in: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!mode_i2c && st_q.cfg.spi_four_wire) |=> !serial_data_oe_o)
        else $error("data pin driven in four-wire");
    // Deselected in SPI mode, neither serial pin may be driven
    chk_cs_active_low: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!mode_i2c && serial_in_o.sel_q) |=> (!serial_data_oe_o && !spi_serial_out_oe_o))
        else $error("drive while deselected");
    chk_lock_follow: assert property (@(posedge clk_i)
        disable iff (rst_i || core_rst)
        1'b1 |=> {lock_lost_loop_d_n_o, lock_lost_loop_c_n_o, lock_lost_loop_a_n_o}
            == $past(loop_locked_i))
        else $error("lock pins stale");
    chk_los_follow: assert property (@(posedge clk_i)
        disable iff (rst_i || core_rst)
        1'b1 |=> {signal_lost_input2_n_o, signal_lost_input1_n_o, signal_lost_input0_n_o}
            == ~$past(signal_lost_status_i))
        else $error("loss pins stale");
endmodule : hpcs_top
`default_nettype wire

/* File: rtl/hpcs_pkg.sv */
// Purpose: Shared types and constants for the host pin control and status block
// Assumes: Three loops (A, C, D), three clock inputs, seven output clocks
// Notes:   Step size is an unsigned magnitude added to or taken from the loop frequency words
`default_nettype none
package hpcs_pkg;
    localparam int NUM_OUTS       = 7;
    localparam int NUM_LOOPS      = 3;
    localparam int NUM_INPUTS     = 3;
    localparam int NUM_OE_PINS    = 3;
    localparam int STEP_W         = 16;
    localparam int FREQ_W         = 32;
    // Reset values of the enable masks: pin zero governs every output
    localparam logic [NUM_OUTS-1:0]  OE0_MASK_RST  = 7'h7F;
    localparam logic [NUM_OUTS-1:0]  OE12_MASK_RST = 7'h00;
    localparam logic [NUM_LOOPS-1:0] STEP_MSK_RST  = 3'h0;
    localparam logic [STEP_W-1:0]    STEP_SIZE_RST = 16'h0001;
    localparam logic [FREQ_W-1:0]    FREQ_RST      = 32'h0000_0000;

    typedef enum logic {HPCS_SPI, HPCS_I2C} hpcs_mode_t;

    // Serial pin bundle as seen from the device side
    typedef struct packed {
        logic data_o;
        logic data_oe;
        logic sel1_o;
        logic sel1_oe;
    } hpcs_serial_out_t;

    typedef struct packed {
        logic                    clk_q;
        logic                    clk_rise;
        logic                    clk_fall;
        logic                    sel_q;
        logic                    data_q;
        logic                    sel1_q;
    } hpcs_serial_in_t;

    // Configuration written by software
    typedef struct packed {
        logic [NUM_OE_PINS-1:0][NUM_OUTS-1:0] oe_mask;
        logic [NUM_LOOPS-1:0]                 step_mask;
        logic [STEP_W-1:0]                    step_size;
        logic                                 spi_four_wire;
    } hpcs_cfg_t;
endpackage : hpcs_pkg
`default_nettype wire

/* File: rtl/hpcs_sync_edge.sv */
// Purpose: Two-flop synchroniser with rise and fall detection
// Assumes: Input is asynchronous to clk_i
// Notes:   Edge detect reads only the second and third stages
`default_nettype none
module hpcs_sync_edge (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } hpcs_sync_t;

    hpcs_sync_t st_q;
    hpcs_sync_t st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = async_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign level_o = st_q.s2;
    assign rise_o  = st_q.s2 & ~st_q.s3;
    assign fall_o  = ~st_q.s2 & st_q.s3;
endmodule : hpcs_sync_edge
`default_nettype wire

/* File: verif/hpcs_host_model.sv */
// Purpose: Host controller and board around the pin block: serial clock, pull-ups
// Assumes: Board fits a pull-up on the data pin and an address strap on the second shared pin
// Notes:   Serial clock stands low between bursts; host never drives the data pin
`default_nettype none
module hpcs_host_model (
    input  wire logic       dut_data_i,
    input  wire logic       dut_data_oe_i,
    input  wire logic       dut_sdo_i,
    input  wire logic       dut_sdo_oe_i,
    input  wire logic       a1_level_i,
    input  wire logic       burst_i,
    input  wire logic [3:0] nbits_i,
    output logic            data_wire_o,
    output logic            sdo_wire_o,
    output logic            serial_clk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released data pin floats up to the pull-up level, never holds the last bit
    assign data_wire_o = dut_data_oe_i ? dut_data_i : 1'b1;
    // Strapped address level shows only while the device leaves the pin alone
    assign sdo_wire_o  = dut_sdo_oe_i ? dut_sdo_i : a1_level_i;
    // One burst of bit clocks at 125 ns, then the clock stands still
    initial
    begin
        serial_clk_o = 1'b0;
        forever
        begin
            @(posedge burst_i);
            repeat (nbits_i)
            begin
                #62.5 serial_clk_o = 1'b1;
                #62.5 serial_clk_o = 1'b0;
            end
        end
    end
endmodule : hpcs_host_model
`default_nettype wire

/* File: verif/hpcs_top_tb.sv */
// Purpose: Self-checking bench for the pin control and status block
// Assumes: Inputs change on the falling edge; outputs are read once settled
// Notes:   Waits of six cycles cover the two-flop pin synchronisers
`default_nettype none
module hpcs_top_tb;
    import hpcs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i, device_reset_n_i, i2c_select_i, serial_clk_i, serial_data_i;
    logic serial_data_o, serial_data_oe_o, addr_select_bit_one_i, spi_serial_out_o;
    logic spi_serial_out_oe_o, shared_select_i, out_enable_pin_zero_n_i;
    logic out_enable_pin_one_n_i, out_enable_pin_two_n_i, freq_step_up_pin_i;
    logic freq_step_down_pin_i, cfg_we_i, tx_bit_i, tx_drive_i, i2c_mode_o, spi_selected_o;
    logic status_change_irq_n_o, irq_clear_i, lock_lost_loop_a_n_o, lock_lost_loop_c_n_o;
    logic lock_lost_loop_d_n_o, signal_lost_input0_n_o, signal_lost_input1_n_o;
    logic signal_lost_input2_n_o, a1_level, burst;
    logic [1:0]                            i2c_addr_bits_o;
    logic [NUM_LOOPS-1:0]                  loop_locked_i;
    logic [NUM_INPUTS-1:0]                 signal_lost_status_i;
    logic [NUM_OUTS-1:0]                   out_clock_enable_o;
    logic [NUM_LOOPS-1:0][FREQ_W-1:0]      loop_freq_word_o;
    hpcs_cfg_t                             cfg_i, cfg_o, cfg;
    hpcs_serial_in_t                       serial_in_o;
    int                                    n_mismatch, check_count, cycles, rise_cnt;
    int                                    fall_cnt, rise_base, fall_base;

    hpcs_top dut (.clk_i, .rst_i, .device_reset_n_i, .i2c_select_i, .serial_clk_i,
        .serial_data_i, .serial_data_o, .serial_data_oe_o, .addr_select_bit_one_i,
        .spi_serial_out_o, .spi_serial_out_oe_o, .shared_select_i, .out_enable_pin_zero_n_i,
        .out_enable_pin_one_n_i, .out_enable_pin_two_n_i, .freq_step_up_pin_i,
        .freq_step_down_pin_i, .cfg_we_i, .cfg_i, .tx_bit_i, .tx_drive_i, .loop_locked_i,
        .signal_lost_status_i, .serial_in_o, .i2c_mode_o, .spi_selected_o, .i2c_addr_bits_o,
        .status_change_irq_n_o, .irq_clear_i, .out_clock_enable_o, .lock_lost_loop_a_n_o,
        .lock_lost_loop_c_n_o, .lock_lost_loop_d_n_o, .signal_lost_input0_n_o,
        .signal_lost_input1_n_o, .signal_lost_input2_n_o, .loop_freq_word_o, .cfg_o);
    hpcs_host_model host (.dut_data_i(serial_data_o), .dut_data_oe_i(serial_data_oe_o),
        .dut_sdo_i(spi_serial_out_o), .dut_sdo_oe_i(spi_serial_out_oe_o),
        .a1_level_i(a1_level), .burst_i(burst), .nbits_i(4'h8),
        .data_wire_o(serial_data_i), .sdo_wire_o(addr_select_bit_one_i),
        .serial_clk_o(serial_clk_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    always @(negedge clk_i)
    begin
        cycles++;
        if (serial_in_o.clk_rise === 1'b1)
            rise_cnt++;
        if (serial_in_o.clk_fall === 1'b1)
            fall_cnt++;
        // Whole run needs about 290 cycles
        if (cycles == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk_word

    task automatic settle();
        repeat (6) @(negedge clk_i);
    endtask : settle

    task automatic cfg_write(input hpcs_cfg_t c);
        cfg_i    = c;
        cfg_we_i = 1'b1;
        @(negedge clk_i);
        cfg_we_i = 1'b0;
        settle();
    endtask : cfg_write

    task automatic step_pins(input logic up, input logic dn);
        freq_step_up_pin_i   = up;
        freq_step_down_pin_i = dn;
        repeat (8) @(negedge clk_i);
        freq_step_up_pin_i   = 1'b0;
        freq_step_down_pin_i = 1'b0;
        settle();
    endtask : step_pins

    initial
    begin
        // Burst starts low so no false clock burst follows time zero
        {rst_i, device_reset_n_i, i2c_select_i, shared_select_i, a1_level, burst} = 6'h3E;
        {out_enable_pin_zero_n_i, out_enable_pin_one_n_i, out_enable_pin_two_n_i} = 3'h0;
        {freq_step_up_pin_i, freq_step_down_pin_i, cfg_we_i, tx_bit_i, tx_drive_i} = 5'h00;
        irq_clear_i = 1'b0;
        cfg_i = '0;
        loop_locked_i = 3'h7;
        signal_lost_status_i = 3'h0;
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        settle();
        chk_word(32'(cfg_o.oe_mask[0]), 32'h0000_007F, "mask0 default");
        chk_word(32'(cfg_o.oe_mask[1]), 32'h0000_0000, "mask1 default");
        chk_word(32'(cfg_o.step_size), 32'h0000_0001, "step default");
        chk_bit(status_change_irq_n_o, 1'b1, "irq default");
        {out_enable_pin_one_n_i, out_enable_pin_two_n_i} = 2'h3;
        settle();
        chk_word(32'(out_clock_enable_o), 32'h0000_007F, "pins 1,2 ignored");
        out_enable_pin_zero_n_i = 1'b1;
        settle();
        chk_word(32'(out_clock_enable_o), 32'h0000_0000, "pin 0 governs");
        {out_enable_pin_zero_n_i, out_enable_pin_one_n_i, out_enable_pin_two_n_i} = 3'h0;
        cfg = '0;
        cfg.oe_mask[0] = 7'h0F;
        cfg.oe_mask[1] = 7'h71;
        cfg.oe_mask[2] = 7'h02;
        cfg.step_mask = 3'h5;
        cfg.step_size = 16'h0010;
        cfg_write(cfg);
        out_enable_pin_one_n_i = 1'b1;
        settle();
        chk_word(32'(out_clock_enable_o), 32'h0000_000E, "mask1 applied");
        {out_enable_pin_one_n_i, out_enable_pin_two_n_i} = 2'h1;
        settle();
        chk_word(32'(out_clock_enable_o), 32'h0000_007D, "mask2 applied");
        out_enable_pin_two_n_i = 1'b0;
        step_pins(1'b1, 1'b0);
        chk_word(loop_freq_word_o[0], 32'h0000_0010, "step up A");
        chk_word(loop_freq_word_o[1], 32'h0000_0000, "unselected C");
        chk_word(loop_freq_word_o[2], 32'h0000_0010, "step up D");
        step_pins(1'b0, 1'b1);
        step_pins(1'b0, 1'b1);
        chk_word(loop_freq_word_o[0], 32'hFFFF_FFF0, "step down A");
        step_pins(1'b1, 1'b1);
        chk_word(loop_freq_word_o[2], 32'hFFFF_FFF0, "up and down");
        loop_locked_i = 3'h6;
        settle();
        chk_bit(lock_lost_loop_a_n_o, 1'b0, "A unlocked");
        chk_bit(lock_lost_loop_c_n_o, 1'b1, "C locked");
        chk_bit(lock_lost_loop_d_n_o, 1'b1, "D locked");
        chk_bit(status_change_irq_n_o, 1'b0, "irq on lock");
        irq_clear_i = 1'b1;
        @(negedge clk_i);
        irq_clear_i = 1'b0;
        settle();
        chk_bit(status_change_irq_n_o, 1'b1, "irq cleared");
        signal_lost_status_i = 3'h2;
        settle();
        chk_bit(signal_lost_input1_n_o, 1'b0, "loss in1");
        chk_bit(signal_lost_input0_n_o, 1'b1, "no loss in0");
        chk_bit(signal_lost_input2_n_o, 1'b1, "no loss in2");
        chk_bit(status_change_irq_n_o, 1'b0, "irq on loss");
        shared_select_i = 1'b0;
        {tx_drive_i, tx_bit_i} = 2'h3;
        settle();
        chk_bit(i2c_mode_o, 1'b1, "i2c mode");
        chk_word(32'(i2c_addr_bits_o), 32'h0000_0002, "i2c address");
        chk_bit(serial_in_o.sel1_q, 1'b1, "bit one seen");
        chk_bit(serial_data_oe_o, 1'b1, "i2c drives");
        chk_bit(serial_data_i, 1'b0, "i2c drives low");
        chk_bit(serial_in_o.data_q, 1'b0, "data pin seen");
        i2c_select_i = 1'b0;
        settle();
        chk_bit(i2c_mode_o, 1'b0, "spi mode");
        chk_bit(spi_selected_o, 1'b1, "select low");
        {tx_drive_i, tx_bit_i} = 2'h2;
        settle();
        chk_bit(serial_data_oe_o, 1'b1, "3-wire drives");
        chk_bit(serial_data_i, 1'b0, "3-wire bit");
        chk_bit(spi_serial_out_oe_o, 1'b0, "3-wire no sdo");
        rise_base = rise_cnt;
        fall_base = fall_cnt;
        burst = 1'b1;
        repeat (110) @(negedge clk_i);
        burst = 1'b0;
        chk_word(32'(rise_cnt - rise_base), 32'h0000_0008, "bit clock rises");
        chk_word(32'(fall_cnt - fall_base), 32'h0000_0008, "bit clock falls");
        chk_bit(serial_in_o.clk_q, 1'b0, "clock idles low");
        cfg.spi_four_wire = 1'b1;
        cfg_write(cfg);
        // Strap low so the output bit is told apart from the released pin
        {tx_bit_i, a1_level} = 2'h2;
        settle();
        chk_bit(serial_data_oe_o, 1'b0, "4-wire input");
        chk_bit(spi_serial_out_oe_o, 1'b1, "4-wire sdo");
        chk_bit(addr_select_bit_one_i, 1'b1, "sdo bit");
        shared_select_i = 1'b1;
        settle();
        chk_bit(spi_selected_o, 1'b0, "select high");
        chk_bit(spi_serial_out_oe_o, 1'b0, "deselect releases");
        device_reset_n_i = 1'b0;
        settle();
        chk_word(32'(out_clock_enable_o), 32'h0000_0000, "reset enables");
        chk_word(32'(cfg_o.oe_mask[1]), 32'h0000_0000, "reset mask1");
        chk_word(loop_freq_word_o[0], 32'h0000_0000, "reset freq");
        chk_bit(status_change_irq_n_o, 1'b1, "reset irq");
        device_reset_n_i = 1'b1;
        settle();
        chk_word(32'(out_clock_enable_o), 32'h0000_007F, "enables back");
        end_of_test();
    end
endmodule : hpcs_top_tb
`default_nettype wire
